//--- ofh_pkg.sv
// Constants and carrier types of the overtemperature fault handler.
// Assumes a 100 MHz core clock and linear-format (5-bit exponent) values.
package ofh_pkg;

    // ------------------------------------------------------------------
    // Command codes
    // ------------------------------------------------------------------
    localparam logic [7:0] CMD_CLEAR_FAULTS   = 8'h03;
    localparam logic [7:0] CMD_OT_FAULT_THR   = 8'h4f;
    localparam logic [7:0] CMD_OT_FAULT_ACT   = 8'h50;

    // ------------------------------------------------------------------
    // Field layout
    // ------------------------------------------------------------------
    localparam int EXP_MSB  = 15;
    localparam int EXP_LSB  = 11;
    localparam int MAN_MSB  = 10;
    localparam int CODE_MSB = 7;
    localparam int CODE_LSB = 6;
    localparam int ATT_MSB  = 5;
    localparam int ATT_LSB  = 3;
    localparam int DLY_MSB  = 2;
    localparam int DLY_LSB  = 0;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [4:0]  THR_EXP_RST = 5'h00;
    localparam logic [10:0] THR_MAN_RST = 11'h07d;
    localparam logic [7:0]  ACT_RST     = 8'h80;
    localparam logic [7:0]  NVM_DEG_RST = 8'h7d;

    // ------------------------------------------------------------------
    // Action codes
    // ------------------------------------------------------------------
    localparam logic [1:0] ACT_IGNORE  = 2'b00;
    localparam logic [1:0] ACT_DELAYED = 2'b01;
    localparam logic [1:0] ACT_IMMED   = 2'b10;
    localparam logic [1:0] ACT_HOLD    = 2'b11;
    localparam logic [2:0] ATT_LATCH   = 3'h0;
    localparam logic [2:0] ATT_FOREVER = 3'h7;

    // ------------------------------------------------------------------
    // Temperatures, fixed point with DEG_FRAC fraction bits
    // ------------------------------------------------------------------
    localparam int DEG_FRAC     = 16;
    localparam int THR_DIS_DEG  = 255;
    localparam int THR_MAX_DEG  = 255;
    localparam int HYST_DEG     = 20;
    localparam int NVM_MAX_DEG  = 160;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int CLK_KHZ        = 100000;
    localparam int DELAY_STEP_MS  = 10;
    localparam int DELAY_STEP_CYC = DELAY_STEP_MS * CLK_KHZ;
    localparam int TMR_W          = 24;
    localparam int RISE_W         = 20;

    // ------------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        logic        valid;
        logic        write;
        logic [7:0]  code;
        logic [15:0] wdata;
    } ofh_cmd_t;

    typedef struct packed {
        logic temp_byte;
        logic temperature_fault_flag;
        logic cml;
    } ofh_status_t;

endpackage

//--- ofh_timer.sv
// Loadable down-counter giving a one-cycle done pulse.
// Assumes load and stop come from logic on the same clock.
`timescale 1ns/100ps
module ofh_timer #(
    parameter int W = 24
) (
    input  wire logic         clk,      // Core clock
    input  wire logic         srst,     // Sync reset, high
    input  wire logic         ce,       // Clock enable
    input  wire logic         load,     // Start counting from load_val
    input  wire logic [W-1:0] load_val, // Cycles until done
    input  wire logic         stop,     // Abandon a running count
    output logic              done_q    // Expiry pulse
);
    logic [W-1:0] cnt_q, cnt_d;
    logic         run_q, run_d, done_d;

    always_comb begin
        cnt_d  = cnt_q;
        run_d  = run_q;
        done_d = 1'b0;
        if (load) begin
            cnt_d = load_val;
            run_d = 1'b1;
        end else if (stop) begin
            run_d = 1'b0;
        end else if (run_q) begin
            if (cnt_q == '0) begin
                run_d  = 1'b0;
                done_d = 1'b1;
            end else begin
                cnt_d = cnt_q - 1'b1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            cnt_q  <= '0;
            run_q  <= 1'b0;
            done_q <= 1'b0;
        end else if (ce) begin
            cnt_q  <= cnt_d;
            run_q  <= run_d;
            done_q <= done_d;
        end
    end
endmodule

//--- ofh_fault_handler.sv
// Overtemperature fault supervision: threshold, action, retry, status.
// Assumes telemetry, warning limit, enable and commands come from
// logic on the same clock; the warning limit register lives elsewhere.
//
// Contract
// - Threshold: 16-bit linear, exponent resets zero
// - Compare at full linear resolution
// - Unsupported write rejected, flag and alert
// - Store rounds to 0..160 whole degrees for restore
// - Threshold 255 degrees disables the check
// - Trip sets status bits and alerts
// - Release only below warning limit
// - Warning above threshold: use 20-degree hysteresis
// - Code 00b ignores, keeps regulating
// - Code 01b waits 10 ms per count
// - Code 10b shuts down at once
// - Code 11b stays off until released
// - Retry zero latches off
// - Retry 1-6: restart_wait_period, then latch after limit
// - Hidden attempts above warning still counted
// - Retry 7 retries without limit
// - Delay zero: no delay, restart_wait_period one rise
// - Delay n: 10 ms n, restart_wait_period n rises
// - Clear in 11b may leave fault held
// - No start-up while fault present
`timescale 1ns/100ps
module ofh_fault_handler #(
    parameter int DELAY_STEP_CYC = ofh_pkg::DELAY_STEP_CYC
) (
    input  wire logic                         clk,          // Core clock
    input  wire logic                         srst,         // Sync reset, high
    input  wire logic                         ce,           // Clock enable
    input  wire ofh_pkg::ofh_cmd_t            cmd,          // Command request
    output ofh_pkg::ofh_status_t              status_q,     // Sticky status bits
    output logic [15:0]                       rdata_q,      // Read data
    output logic                              smb_alert_n_q,// Host alert, low
    input  wire logic                         temp_valid,   // Telemetry update
    input  wire logic [15:0]                  temp_value,   // Die temp, linear
    input  wire logic [15:0]                  warn_limit,   // Warning limit
    input  wire logic [ofh_pkg::RISE_W-1:0]   ton_rise_cyc, // Rise time, cycles
    input  wire logic                         enable,       // Output on request
    input  wire logic                         nvm_store,    // Save threshold
    input  wire logic                         nvm_restore,  // Reload threshold
    output logic                              power_en_q,   // Power stage on
    output logic                              temperature_fault_flag, // Fault held
    output logic                              latched_off_q // Latched off
);
    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    typedef logic signed [47:0] ofh_fix_t;
    typedef enum logic [6:0] {
        ST_OFF    = 7'b0000001,
        ST_START  = 7'b0000010,
        ST_RUN    = 7'b0000100,
        ST_DELAY  = 7'b0001000,
        ST_RESTART_WAIT_PERIOD = 7'b0010000,
        ST_HOLD   = 7'b0100000,
        ST_LATCH  = 7'b1000000
    } ofh_state_t;

    function automatic ofh_fix_t lin_to_fix(input logic [15:0] v);
        ofh_fix_t   m;
        logic [4:0] sh;
        m  = 48'(signed'(v[ofh_pkg::MAN_MSB:0]));
        sh = v[ofh_pkg::EXP_MSB:ofh_pkg::EXP_LSB] + 5'h10;
        return m <<< sh;
    endfunction

    function automatic ofh_fix_t deg(input int d);
        return ofh_fix_t'(d) <<< ofh_pkg::DEG_FRAC;
    endfunction

    // ------------------------------------------------------------------
    // Register file and status
    // ------------------------------------------------------------------
    logic [15:0]          thr_q, thr_d;
    logic [7:0]           act_q, act_d;
    logic [7:0]           nvm_q, nvm_d;
    ofh_pkg::ofh_status_t status_d;
    logic [15:0]          rdata_d;
    logic                 flt_q, flt_d;
    ofh_fix_t             thr_fix, warn_fix, tel_fix, rel_fix, wr_fix, rnd_fix;
    logic                 thr_dis, trg_evt, rel_evt, wr_thr, wr_bad, clr;
    logic [1:0]           code;
    logic [2:0]           retry, dsel;

    always_comb begin
        thr_fix  = lin_to_fix(thr_q);
        warn_fix = lin_to_fix(warn_limit);
        tel_fix  = lin_to_fix(temp_value);
        wr_fix   = lin_to_fix(cmd.wdata);
        rnd_fix  = (thr_fix + deg(1) / 2) >>> ofh_pkg::DEG_FRAC;
        thr_dis  = (thr_fix == deg(ofh_pkg::THR_DIS_DEG));
        // Warning above threshold would release with no hysteresis
        rel_fix  = (warn_fix > thr_fix) ? thr_fix - deg(ofh_pkg::HYST_DEG)
                                        : warn_fix;
        trg_evt  = temp_valid && !thr_dis && (tel_fix >= thr_fix);
        rel_evt  = temp_valid && flt_q && !trg_evt && (tel_fix < rel_fix);
        wr_thr   = cmd.valid && cmd.write && (cmd.code == ofh_pkg::CMD_OT_FAULT_THR);
        wr_bad   = wr_thr && ((wr_fix < deg(0)) || (wr_fix > deg(ofh_pkg::THR_MAX_DEG)));
        clr      = cmd.valid && cmd.write && (cmd.code == ofh_pkg::CMD_CLEAR_FAULTS);
        code     = act_q[ofh_pkg::CODE_MSB:ofh_pkg::CODE_LSB];
        retry    = act_q[ofh_pkg::ATT_MSB:ofh_pkg::ATT_LSB];
        dsel     = act_q[ofh_pkg::DLY_MSB:ofh_pkg::DLY_LSB];

        thr_d = thr_q;
        act_d = act_q;
        nvm_d = nvm_q;
        if (wr_thr && !wr_bad)
            thr_d = cmd.wdata;
        if (cmd.valid && cmd.write && cmd.code == ofh_pkg::CMD_OT_FAULT_ACT)
            act_d = cmd.wdata[7:0];
        if (nvm_store) begin
            if (rnd_fix < 0)
                nvm_d = 8'h00;
            else if (rnd_fix > ofh_fix_t'(ofh_pkg::NVM_MAX_DEG))
                nvm_d = 8'(ofh_pkg::NVM_MAX_DEG);
            else
                nvm_d = rnd_fix[7:0];
        end
        if (nvm_restore)
            thr_d = {ofh_pkg::THR_EXP_RST, 3'h0, nvm_q};

        // A trip in the clearing cycle survives the clear
        flt_d = flt_q;
        if (clr || rel_evt)
            flt_d = 1'b0;
        if (trg_evt)
            flt_d = 1'b1;

        status_d = status_q;
        if (clr)
            status_d = '0;
        if (trg_evt) begin
            status_d.temp_byte = 1'b1;
            status_d.temperature_fault_flag = 1'b1;
        end
        if (wr_bad)
            status_d.cml = 1'b1;

        rdata_d = rdata_q;
        if (cmd.valid && !cmd.write) begin
            unique case (cmd.code)
                ofh_pkg::CMD_OT_FAULT_THR:   rdata_d = thr_q;
                ofh_pkg::CMD_OT_FAULT_ACT:   rdata_d = {8'h00, act_q};
                default:                     rdata_d = 16'h0000;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            thr_q         <= {ofh_pkg::THR_EXP_RST, ofh_pkg::THR_MAN_RST};
            act_q         <= ofh_pkg::ACT_RST;
            nvm_q         <= ofh_pkg::NVM_DEG_RST;
            flt_q         <= 1'b0;
            status_q      <= '0;
            rdata_q       <= 16'h0000;
            smb_alert_n_q <= 1'b1;
        end else if (ce) begin
            thr_q         <= thr_d;
            act_q         <= act_d;
            nvm_q         <= nvm_d;
            flt_q         <= flt_d;
            status_q      <= status_d;
            rdata_q       <= rdata_d;
            smb_alert_n_q <= !(status_d.temperature_fault_flag || status_d.cml);
        end
    end

    assign temperature_fault_flag = flt_q;

    // ------------------------------------------------------------------
    // Response and retry sequencer
    // ------------------------------------------------------------------
    ofh_state_t                st_q, st_d;
    logic [2:0]                att_q, att_d, att_inc;
    logic                      tmr_load, tmr_stop, tmr_done, out_of_tries, inc_out;
    logic [ofh_pkg::TMR_W-1:0] tmr_val, hic_cyc, dly_cyc;
    logic                      power_en_d, latched_d;

    always_comb begin
        att_inc = att_q + 3'h1;
        // Delay zero still waits one full rise
        hic_cyc = ofh_pkg::TMR_W'(ton_rise_cyc) *
                  ofh_pkg::TMR_W'((dsel == 3'h0) ? 3'h1 : dsel);
        dly_cyc = ofh_pkg::TMR_W'(32'(dsel) * DELAY_STEP_CYC);
        out_of_tries = (retry == ofh_pkg::ATT_LATCH) ||
                       (retry != ofh_pkg::ATT_FOREVER && att_q >= retry);
        inc_out = (retry != ofh_pkg::ATT_FOREVER) && (att_inc >= retry);
        st_d     = st_q;
        att_d    = att_q;
        tmr_load = 1'b0;
        tmr_val  = hic_cyc;
        unique case (st_q)
            ST_OFF: begin
                att_d = 3'h0;
                if (enable && !flt_q) begin
                    st_d     = ST_START;
                    tmr_load = 1'b1;
                    tmr_val  = ofh_pkg::TMR_W'(ton_rise_cyc);
                end
            end
            ST_START, ST_RUN: begin
                if (st_q == ST_START && tmr_done) begin
                    st_d  = ST_RUN;
                    att_d = 3'h0;
                end
                if (flt_q) begin
                    unique case (code)
                        ofh_pkg::ACT_IGNORE: st_d = st_d;
                        ofh_pkg::ACT_DELAYED: begin
                            st_d     = ST_DELAY;
                            tmr_load = 1'b1;
                            tmr_val  = dly_cyc;
                        end
                        ofh_pkg::ACT_IMMED: begin
                            st_d     = out_of_tries ? ST_LATCH : ST_RESTART_WAIT_PERIOD;
                            tmr_load = !out_of_tries;
                        end
                        ofh_pkg::ACT_HOLD: st_d = ST_HOLD;
                    endcase
                end
            end
            ST_DELAY: begin
                if (!flt_q) begin
                    st_d = ST_RUN;
                end else if (tmr_done) begin
                    st_d     = out_of_tries ? ST_LATCH : ST_RESTART_WAIT_PERIOD;
                    tmr_load = !out_of_tries;
                end
            end
            ST_RESTART_WAIT_PERIOD: begin
                if (tmr_done) begin
                    att_d = att_inc;
                    if (!flt_q) begin
                        st_d     = ST_START;
                        tmr_load = 1'b1;
                        tmr_val  = ofh_pkg::TMR_W'(ton_rise_cyc);
                    end else if (inc_out) begin
                        st_d = ST_LATCH;
                    end else begin
                        tmr_load = 1'b1;
                    end
                end
            end
            ST_HOLD: begin
                // Only a real drop below release frees it
                if (rel_evt) begin
                    st_d     = out_of_tries ? ST_LATCH : ST_RESTART_WAIT_PERIOD;
                    tmr_load = !out_of_tries;
                end
            end
            ST_LATCH: st_d = ST_LATCH;
        endcase
        if (!enable) begin
            st_d     = ST_OFF;
            tmr_load = 1'b0;
        end
        tmr_stop   = (st_d != st_q) && !tmr_load;
        power_en_d = (st_d == ST_START) || (st_d == ST_RUN) || (st_d == ST_DELAY);
        latched_d  = (st_d == ST_LATCH);
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            st_q          <= ST_OFF;
            att_q         <= 3'h0;
            power_en_q    <= 1'b0;
            latched_off_q <= 1'b0;
        end else if (ce) begin
            st_q          <= st_d;
            att_q         <= att_d;
            power_en_q    <= power_en_d;
            latched_off_q <= latched_d;
        end
    end

    ofh_timer #(.W(ofh_pkg::TMR_W)) u_timer (
        .clk      (clk),
        .srst     (srst),
        .ce       (ce),
        .load     (tmr_load && ce),
        .load_val (tmr_val),
        .stop     (tmr_stop),
        .done_q   (tmr_done)
    );

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    sequence s_trip;
        ce && trg_evt;
    endsequence

    sequence s_imm_fault;
        ce && enable && st_q == ST_RUN && flt_q && code == ofh_pkg::ACT_IMMED;
    endsequence

    a_trip_sets_status: assert property (s_trip |=>
                                         status_q.temperature_fault_flag
                                         && status_q.temp_byte && !smb_alert_n_q)
        else $error("trip did not set status and alert");
    a_disabled_no_trip: assert property (ce && temp_valid && thr_dis && !flt_q && !clr
                                         |=> !flt_q)
        else $error("disabled threshold still tripped");
    a_bad_write_kept: assert property (ce && wr_bad && !nvm_restore
                                       |=> status_q.cml && $stable(thr_q))
        else $error("unsupported threshold accepted");
    a_ignore_keeps_run: assert property (ce && enable && st_q == ST_RUN
                                         && code == ofh_pkg::ACT_IGNORE |=> st_q == ST_RUN)
        else $error("ignore mode left run");
    a_imm_shutdown: assert property (s_imm_fault |=> !power_en_q)
        else $error("immediate action kept power on");
    a_imm_latch_zero: assert property (s_imm_fault ##0 (retry == ofh_pkg::ATT_LATCH)
                                       |=> latched_off_q)
        else $error("retry zero did not latch");
    a_delay_powered: assert property (ce && enable && st_q == ST_RUN && flt_q
                                      && code == ofh_pkg::ACT_DELAYED
                                      |=> st_q == ST_DELAY && power_en_q)
        else $error("power dropped during shutdown delay");
    a_hidden_attempt: assert property (ce && enable && st_q == ST_RESTART_WAIT_PERIOD && tmr_done
                                       && flt_q |=> !power_en_q)
        else $error("power visible during restart_wait_period");
    a_no_fault_start: assert property (ce && st_q == ST_OFF && flt_q |=> st_q != ST_START)
        else $error("started with fault present");
    a_hold_waits: assert property (ce && enable && st_q == ST_HOLD && !rel_evt
                                   |=> st_q == ST_HOLD [*1])
        else $error("hold left before release");
    a_release_clears: assert property (ce && rel_evt && !clr |=> !flt_q)
        else $error("release did not clear fault");
endmodule

//--- ofh_host.sv
// Host model that issues register commands to the fault handler.
// Assumes the handler samples cmd on rising edges of clk.
`timescale 1ns/100ps
module ofh_host (
    input  wire logic         clk, // Core clock
    output ofh_pkg::ofh_cmd_t cmd  // Command request
);
    initial cmd = '0;

    // Released fields carry junk so a stale value can never pass as valid
    task automatic send(input logic w, input logic [7:0] c, input logic [15:0] d);
        @(negedge clk);
        cmd = {1'b1, w, c, d};
        @(negedge clk);
        cmd = {1'b0, ~w, ~c, ~d};
    endtask
endmodule

//--- tb_overtemp_fault_handler.sv
// Self-checking bench of the overtemperature fault handler.
// Assumes the host model ofh_host and a 20-cycle delay step.
`timescale 1ns/100ps
module tb_overtemp_fault_handler;
    logic clk, srst, temp_valid, enable;
    logic [15:0] temp_value, warn_limit;
    logic [15:0] rdata;
    logic alert_n, pwr, flag, latched, nvm_st, nvm_rs;
    ofh_pkg::ofh_cmd_t cmd;
    ofh_pkg::ofh_status_t st;
    int seed, miscompares, n_tests, cyc, t;

    ofh_host host (.clk(clk), .cmd(cmd));
    ofh_fault_handler #(.DELAY_STEP_CYC(20)) dut (
        .clk(clk), .srst(srst), .ce(1'b1), .cmd(cmd), .status_q(st),
        .rdata_q(rdata), .smb_alert_n_q(alert_n), .temp_valid(temp_valid),
        .temp_value(temp_value), .warn_limit(warn_limit), .ton_rise_cyc(20'h0000a),
        .enable(enable), .nvm_store(nvm_st), .nvm_restore(nvm_rs), .power_en_q(pwr),
        .temperature_fault_flag(flag), .latched_off_q(latched));

    always #5 clk = ~clk;
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            miscompares++;
            close_out();
        end
    end

    function automatic logic [15:0] lin(input int d);
        return {5'h00, 11'(d)};
    endfunction

    task automatic close_out();
        $display("miscompares=%0d n_tests=%0d", miscompares, n_tests);
        if (miscompares == 0 && n_tests > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] c, input logic [15:0] d);
        host.send(1'b1, c, d);
    endtask

    task automatic rd(input logic [7:0] c, input logic [15:0] e);
        host.send(1'b0, c, 16'h0000);
        chk(rdata, e);
    endtask

    task automatic tv(input logic [15:0] v);
        @(negedge clk);
        temp_value = v;
        temp_valid = 1'b1;
        @(negedge clk);
        temp_valid = 1'b0;
        temp_value = ~v;
    endtask

    // One-cycle store (s high) or restore (s low) pulse
    task automatic nv(input logic s);
        @(negedge clk);
        nvm_st = s;
        nvm_rs = !s;
        @(negedge clk);
        {nvm_st, nvm_rs} = 2'b00;
    endtask

    // Waits up to n cycles for the power stage to reach v
    task automatic wt(input logic v, input int n);
        for (int k = 0; k < n && pwr !== v; k++) @(negedge clk);
        chk(16'(pwr), 16'(v));
    endtask

    task automatic hd(input logic v, input int n);
        repeat (n) begin
            @(negedge clk);
            chk(16'(pwr), 16'(v));
        end
    endtask

    // Start-up with no fault at enable, then a 130-degree sample over the 125-degree threshold
    task automatic up(input logic [7:0] act);
        srst = 1'b1;
        enable = 1'b0;
        repeat (2) @(negedge clk);
        srst = 1'b0;
        wr(8'h50, {8'h00, act});
        enable = 1'b1;
        wt(1'b1, 5);
        repeat (20) @(negedge clk);
        tv(lin(130));
    endtask

    initial begin
        {clk, temp_valid, enable, nvm_st, nvm_rs, miscompares, n_tests} = '0;
        seed = 22;
        srst = 1'b1;
        temp_value = lin(25);
        warn_limit = lin(110);
        repeat (10) @(negedge clk);
        srst = 1'b0;
        rd(8'h4f, 16'h007d);
        rd(8'h50, 16'h0080);
        wr(8'h4f, 16'h012c);
        rd(8'h4f, 16'h007d);
        chk(16'(st), 16'h0001);
        chk(16'(alert_n), 16'h0000);
        warn_limit = lin(0);
        for (int i = 0; i < 4; i++) begin
            t = 1 + int'($unsigned($random(seed)) % 160);
            wr(8'h03, 16'h0000);
            wr(8'h4f, lin(t));
            rd(8'h4f, lin(t));
            tv({5'h1f, 11'(2 * t - 1)});
            chk(16'(flag), 16'h0000);
            tv(lin(t));
            chk(16'(flag), 16'h0001);
            chk(16'(st), 16'h0006);
            chk(16'(alert_n), 16'h0000);
        end
        wr(8'h03, 16'h0000);
        wr(8'h4f, lin(100));
        warn_limit = lin(90);
        tv(lin(100));
        tv(lin(95));
        chk(16'(flag), 16'h0001);
        tv(lin(89));
        chk(16'(flag), 16'h0000);
        warn_limit = lin(120);
        tv(lin(100));
        tv(lin(80));
        chk(16'(flag), 16'h0001);
        tv(lin(79));
        chk(16'(flag), 16'h0000);
        wr(8'h4f, lin(255));
        tv(lin(300));
        chk(16'(flag), 16'h0000);
        wr(8'h4f, {5'h1e, 11'h1f7});
        nv(1'b1);
        wr(8'h4f, lin(40));
        nv(1'b0);
        rd(8'h4f, 16'h007e);
        wr(8'h4f, lin(200));
        nv(1'b1);
        nv(1'b0);
        rd(8'h4f, 16'h00a0);
        warn_limit = lin(110);
        up(8'h80);
        wt(1'b0, 3);
        repeat (5) @(negedge clk);
        chk(16'(latched), 16'h0001);
        up(8'h88);
        wt(1'b0, 3);
        hd(1'b0, 40);
        chk(16'(latched), 16'h0001);
        up(8'hb8);
        hd(1'b0, 80);
        chk(16'(latched), 16'h0000);
        tv(lin(50));
        wt(1'b1, 40);
        up(8'h42);
        hd(1'b1, 35);
        wt(1'b0, 20);
        up(8'hd0);
        wt(1'b0, 3);
        tv(lin(115));
        hd(1'b0, 30);
        tv(lin(100));
        wt(1'b1, 40);
        tv(lin(130));
        wt(1'b0, 3);
        tv(lin(115));
        wr(8'h03, 16'h0000);
        tv(lin(100));
        hd(1'b0, 30);
        up(8'h00);
        hd(1'b1, 30);
        enable = 1'b0;
        wt(1'b0, 3);
        enable = 1'b1;
        hd(1'b0, 30);
        close_out();
    end
endmodule
